// >>> bench/cpu_fifo_port_mode_select_asserts.sv
/* checker for the cpu fifo port block: role select, clock steering and
   the side effects of port accesses; sees only the top module's ports */
`timescale 1ns/1ps
`default_nettype none
`include "cpu_fifo_port_map.svh"

module cpu_fifo_port_mode_select_asserts
    import cpu_fifo_port_pkg::*;
(
    input wire logic                     hclk,
    input wire logic                     hresetn,
    input wire logic                     ce,
    input wire logic                     hsel,
    input wire cpu_fifo_port_pkg::word_t haddr,
    input wire logic [1:0]               htrans,
    input wire logic                     hwrite,
    input wire logic                     hready,
    input wire cpu_fifo_port_pkg::word_t hwdata,
    input wire cpu_fifo_port_pkg::word_t hrdata,
    input wire logic                     hreadyout,
    input wire logic                     hresp,
    input wire logic                     sleep_mode,
    input wire logic                     cpu_pop_attach,
    input wire logic                     role_is_host,
    input wire logic                     shared_clk_en,
    input wire logic                     device_clk_en,
    input wire logic                     host_clk_en,
    input wire logic                     eng_in_ready,
    input wire logic                     eng_out_valid,
    input wire cpu_fifo_port_pkg::byte_t eng_out_data,
    input wire logic                     eng_out_ready
);
    logic acc;
    logic pop_adr;
    logic push_adr;
    logic push_pend_r;
    logic push_done_r;
    logic pop_took_r;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // decode of an accepted address phase
    assign acc = hsel && hready && htrans[`HTRANS_NONSEQ_BIT] && ce;
    assign pop_adr = haddr[7:3] == 5'h10 && haddr[2] == 1'b0 || haddr == 32'h84;
    assign push_adr = haddr == 32'h88 || haddr == 32'h8C;

    // push commits one edge after its address phase, so track it
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            push_pend_r <= 1'b0;
            push_done_r <= 1'b0;
            pop_took_r <= 1'b0;
        end
        else
        begin
            push_pend_r <= acc ? hwrite && push_adr : push_pend_r && !(hready && ce);
            push_done_r <= push_pend_r && hready && ce;
            pop_took_r <= acc && !hwrite && pop_adr;
        end

    sequence role_wr_s;
        acc && hwrite && haddr == 32'h7C;
    endsequence
    sequence data_s;
        hready && ce;
    endsequence

    a_role_write:
        assert property (role_wr_s ##1 data_s |=> role_is_host == $past(hwdata[0]))
        else $error("role bit did not follow write data");
    a_role_read:
        assert property (acc && !hwrite && haddr == 32'h7C
                         |=> hrdata == {31'h0, $past(role_is_host)})
        else $error("role select read wrong");
    a_clk_device:
        assert property (!role_is_host |-> device_clk_en && !host_clk_en && shared_clk_en)
        else $error("device role clock steering wrong");
    a_clk_host:
        assert property (role_is_host |-> host_clk_en && !device_clk_en && shared_clk_en)
        else $error("host role clock steering wrong");
    a_pop_refused:
        assert property (acc && !hwrite && pop_adr && (!cpu_pop_attach || sleep_mode)
                         |=> hrdata == 32'h0)
        else $error("pop while not joined returned data");
    a_count_valid:
        assert property (acc && !hwrite && haddr == 32'h90
                         |=> hrdata[7:5] == {$past(cpu_pop_attach), 2'h0})
        else $error("readable count valid bit wrong");
    a_out_hold:
        assert property (eng_out_valid && !(eng_out_ready && ce)
                         |=> eng_out_valid && $stable(eng_out_data))
        else $error("push area head moved without a drain");
    a_push_cause:
        assert property ($rose(eng_out_valid) |-> push_done_r)
        else $error("push area filled without a port write");
    a_pop_cause:
        assert property ($rose(eng_in_ready) |-> pop_took_r)
        else $error("pop area freed without a port read");
    a_ready_ce:
        assert property (hreadyout == ce && hresp == `HRESP_OKAY)
        else $error("ready or response wrong");
endmodule

bind cpu_fifo_port_mode_select cpu_fifo_port_mode_select_asserts u_chk (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_mode(sleep_mode),
    .cpu_pop_attach(cpu_pop_attach), .role_is_host(role_is_host),
    .shared_clk_en(shared_clk_en), .device_clk_en(device_clk_en),
    .host_clk_en(host_clk_en), .eng_in_ready(eng_in_ready),
    .eng_out_valid(eng_out_valid), .eng_out_data(eng_out_data),
    .eng_out_ready(eng_out_ready));
`default_nettype wire

// >>> bench/cpu_fifo_port_mode_select_bench.sv
/* self-checking bench: ahb-lite master tasks, engine model on the far
   side; assumes the block answers with zero wait states while ce is high */
`timescale 1ns/1ps
`default_nettype none
`include "cpu_fifo_port_map.svh"

module cpu_fifo_port_mode_select_bench;
    import cpu_fifo_port_pkg::*;
    logic       hclk = 1'b0;
    logic       hresetn = 1'b0;
    logic       ce = 1'b1;
    logic       hsel = 1'b0;
    word_t      haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic       hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    word_t      hwdata = 32'h0;
    logic       sleep_mode = 1'b0;
    logic       pop_att = 1'b0;
    logic       push_att = 1'b0;
    logic       stall = 1'b1;
    word_t      hrdata;
    logic       hreadyout, hresp, role, shared_en, dev_en, host_en;
    logic       in_valid, in_ready, out_valid, out_ready;
    byte_t      in_data, out_data;
    int         n_mismatch = 0;
    int         checks = 0;
    int         i;

    always #12.5 hclk = ~hclk;

    cpu_fifo_port_mode_select dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sleep_mode(sleep_mode), .cpu_pop_attach(pop_att),
        .cpu_push_attach(push_att), .role_is_host(role), .shared_clk_en(shared_en),
        .device_clk_en(dev_en), .host_clk_en(host_en), .eng_in_valid(in_valid),
        .eng_in_data(in_data), .eng_in_ready(in_ready), .eng_out_valid(out_valid),
        .eng_out_data(out_data), .eng_out_ready(out_ready));

    engine_model eng (.hclk(hclk), .hresetn(hresetn), .ce(ce), .stall(stall),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));

    task automatic chk(input word_t got, input word_t exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one single transfer; holds each phase until ready is sampled high,
    // only the watchdog ends a wait that never finishes
    task automatic bus(input logic wr, input reg_idx_t idx, input word_t wd,
                       output word_t rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, idx, 2'h0};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        if (wr)
            hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input reg_idx_t idx, input word_t d);
        word_t x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rd(input reg_idx_t idx, input word_t exp);
        word_t x;
        bus(1'b0, idx, 32'h0, x);
        chk(x, exp);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        chk({28'h0, shared_en, role, host_en, dev_en}, 32'h9);
        rd(`IDX_ROLE_SELECT, 32'h0);
        wr(`IDX_ROLE_SELECT, 32'hFF);
        rd(`IDX_ROLE_SELECT, 32'h1);
        chk({28'h0, shared_en, role, host_en, dev_en}, 32'hE);
        sleep_mode <= 1'b1;
        wr(`IDX_ROLE_SELECT, 32'hFE);
        rd(`IDX_ROLE_SELECT, 32'h0);
        chk({28'h0, shared_en, role, host_en, dev_en}, 32'h9);
        sleep_mode <= 1'b0;
        wr(6'h30, 32'hFF);
        rd(6'h30, 32'h0);
        rd(`IDX_PUSH_PORT_A, 32'h0);
        $display("test role done");
        // fill the pop area to full before it is joined
        for (i = 0; i < 64; i++) eng.feed(i[7:0]);
        for (i = 0; i < 300 && in_ready !== 1'b0; i++) @(posedge hclk);
        rd(`IDX_READABLE_HIGH, 32'h0);
        rd(`IDX_POP_PORT_A, 32'h0);
        pop_att <= 1'b1;
        sleep_mode <= 1'b1;
        rd(`IDX_POP_PORT_A, 32'h0);
        sleep_mode <= 1'b0;
        rd(`IDX_READABLE_HIGH, 32'h80);
        rd(`IDX_READABLE_LOW, 32'h40);
        for (i = 0; i < 64; i++)
            rd(i[0] ? `IDX_POP_PORT_B : `IDX_POP_PORT_A, i);
        rd(`IDX_READABLE_HIGH, 32'h80);
        rd(`IDX_READABLE_LOW, 32'h0);
        eng.feed(8'h5A);
        eng.feed(8'hC3);
        repeat (4) @(posedge hclk);
        rd(`IDX_POP_PORT_B, 32'h0);
        rd(`IDX_POP_PORT_A, 32'h5A);
        rd(`IDX_POP_PORT_A, 32'h0);
        rd(`IDX_POP_PORT_B, 32'hC3);
        $display("test pop done");
        // push with the engine stalled, byte boundary refusals between
        push_att <= 1'b1;
        wr(`IDX_PUSH_PORT_A, 32'hAA);
        wr(`IDX_PUSH_PORT_B, 32'hBB);
        wr(`IDX_PUSH_PORT_B, 32'h11);
        wr(`IDX_PUSH_PORT_A, 32'hCC);
        wr(`IDX_PUSH_PORT_A, 32'h22);
        wr(`IDX_PUSH_PORT_B, 32'hDD);
        rd(`IDX_FREE_HIGH, 32'h0);
        rd(`IDX_FREE_LOW, 32'h3C);
        push_att <= 1'b0;
        wr(`IDX_PUSH_PORT_A, 32'h33);
        stall <= 1'b0;
        repeat (10) @(posedge hclk);
        chk(eng.got_q.size(), 32'h4);
        for (i = 0; i < 4; i++)
            chk(eng.got_q[i], 32'hAA + 32'h11 * i);
        ce <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({31'h0, hreadyout}, 32'h0);
        ce <= 1'b1;
        $display("test push done");
        end_sim();
    end

    // watchdog: the tests need well under 2000 cycles
    initial
    begin
        #(25 * 5000);
        n_mismatch++;
        end_sim();
    end
endmodule
`default_nettype wire

// >>> bench/engine_model.sv
/* usb engine stand-in: fills the pop area from a queue and drains the
   push area into a queue; assumes the block's clock and active-low reset */
`timescale 1ns/1ps
`default_nettype none

module engine_model
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       ce,
    input  wire logic       stall,
    output logic            in_valid,
    output logic [7:0]      in_data,
    input  wire logic       in_ready,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_data,
    output logic            out_ready
);
    logic [7:0] feed_q[$];
    logic [7:0] got_q[$];

    task automatic feed(input logic [7:0] b);
        feed_q.push_back(b);
    endtask

    // offer holds until taken; idle data toggles so no stale byte looks valid
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            in_valid <= 1'b0;
            in_data <= 8'h00;
        end
        else if (!in_valid || (in_ready && ce))
        begin
            in_valid <= feed_q.size() > 0;
            in_data <= (feed_q.size() > 0) ? feed_q.pop_front() : ~in_data;
        end

    // drain side; stall models a slow engine
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            out_ready <= 1'b0;
        else
        begin
            if (out_valid && out_ready && ce)
                got_q.push_back(out_data);
            out_ready <= !stall;
        end
endmodule
`default_nettype wire

// >>> rtl/cpu_byte_fifo.sv
/*
 * byte-wide fifo area held in flip-flops, with pointer parity outputs so the
 * port logic can see a byte boundary; assumes one clock, active-low async
 * reset and a clock enable that freezes everything
 */
`timescale 1ns/1ps
`default_nettype none
`include "cpu_fifo_port_map.svh"

module cpu_byte_fifo
    import cpu_fifo_port_pkg::*;
(
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         ce,
    input  wire logic                         push,
    input  wire cpu_fifo_port_pkg::byte_t     push_data,
    input  wire logic                         pop,
    output cpu_fifo_port_pkg::byte_t          head_data,
    output cpu_fifo_port_pkg::fifo_cnt_t      count,
    output logic                              full,
    output logic                              empty,
    output logic                              rd_parity,
    output logic                              wr_parity
);

    byte_t                     mem_r [`FIFO_DEPTH];
    logic [`FIFO_PTR_W-1:0]    rptr_r;
    logic [`FIFO_PTR_W-1:0]    wptr_r;
    fifo_cnt_t                 count_r;
    logic                      do_push;
    logic                      do_pop;

    // refuse a push when full and a pop when empty so pointers never pass
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;

    // storage written by index; no reset, contents are don't care until pushed
    always_ff @(posedge hclk)
    begin
        if (ce && do_push)
        begin
            mem_r[wptr_r] <= push_data;
        end
    end

    // pointers wrap naturally at the power-of-two depth
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rptr_r <= '0;
            wptr_r <= '0;
        end
        else if (ce)
        begin
            if (do_push)
            begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (do_pop)
            begin
                rptr_r <= rptr_r + 1'b1;
            end
        end
    end

    // fill level; simultaneous push and pop leaves it unchanged
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count_r <= '0;
        end
        else if (ce && (do_push != do_pop))
        begin
            count_r <= do_push ? count_r + 1'b1 : count_r - 1'b1;
        end
    end

    assign head_data = mem_r[rptr_r];
    assign count     = count_r;
    assign full      = (count_r == `FIFO_DEPTH);
    assign empty     = (count_r == '0);
    assign rd_parity = rptr_r[0];
    assign wr_parity = wptr_r[0];

endmodule

`default_nettype wire

// >>> rtl/cpu_fifo_port_map.svh
/*
 * register indices, field positions, reset values and sizes of the cpu fifo
 * port block; assumes nothing beyond a single inclusion per unit
 */
`ifndef CPU_FIFO_PORT_MAP_SVH
`define CPU_FIFO_PORT_MAP_SVH

// register indices; byte address is four times the index
`define IDX_ROLE_SELECT      6'h1F
`define IDX_POP_PORT_A       6'h20
`define IDX_POP_PORT_B       6'h21
`define IDX_PUSH_PORT_A      6'h22
`define IDX_PUSH_PORT_B      6'h23
`define IDX_READABLE_HIGH    6'h24
`define IDX_READABLE_LOW     6'h25
`define IDX_FREE_HIGH        6'h26
`define IDX_FREE_LOW         6'h27

// address decode slices
`define ADDR_IDX_MSB         7
`define ADDR_IDX_LSB         2
`define ADDR_TOP_MSB         31
`define ADDR_TOP_LSB         8

// role select field
`define ROLE_BIT             0
`define ROLE_RESET           1'b0

// readable count high and low layout
`define READ_VALID_BIT       7
`define COUNT_HIGH_MSB       12
`define COUNT_HIGH_LSB       8
`define COUNT_LOW_MSB        7
`define COUNT_LOW_LSB        0

// fifo geometry (flip-flop storage)
`define FIFO_DEPTH           7'h40
`define FIFO_PTR_W           6
`define FIFO_CNT_W           7
`define COUNT_PAD            6'h00

// side of a 16-bit fifo word that each port byte carries
`define SIDE_A               1'b0
`define SIDE_B               1'b1

// ahb codes
`define HTRANS_NONSEQ_BIT    1
`define HRESP_OKAY           1'b0
`define BYTE_ZERO            8'h00
`define WORD_ZERO            32'h0000_0000

`endif

// >>> rtl/cpu_fifo_port_mode_select.sv
/*
 * cpu-facing fifo data ports and host/device role select, reached as an
 * ahb-lite slave; one fifo area is joined for popping (filled by the usb
 * engine) and one for pushing (drained by the usb engine).
 * assumes the join configuration lives elsewhere and arrives as two levels,
 * and that the sleep level comes from the power controller.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cpu_fifo_port_map.svh"

// Summary of operation
// - role select bit 0 picks the role: 0 peripheral, 1 host.
// - role select stays readable, writable and effective during sleep.
// - role 0 runs shared and peripheral engine clocks, stops host engine clock.
// - role 1 runs shared and host engine clocks, stops peripheral engine clock.
// - pop port reads return data from the fifo area joined for reading.
// - at a byte boundary only one pop port byte carries valid data.
// - push port writes store data into the fifo area joined for writing.
// - at a byte boundary only one push port byte is stored.
// - readable count split high/low; read high first, low is a snapshot.
module cpu_fifo_port_mode_select
    import cpu_fifo_port_pkg::*;
(
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         ce,
    input  wire logic                         hsel,
    input  wire cpu_fifo_port_pkg::word_t     haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic                         hready,
    input  wire cpu_fifo_port_pkg::word_t     hwdata,
    output cpu_fifo_port_pkg::word_t          hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    input  wire logic                         sleep_mode,
    input  wire logic                         cpu_pop_attach,
    input  wire logic                         cpu_push_attach,
    output logic                              role_is_host,
    output logic                              shared_clk_en,
    output logic                              device_clk_en,
    output logic                              host_clk_en,
    input  wire logic                         eng_in_valid,
    input  wire cpu_fifo_port_pkg::byte_t     eng_in_data,
    output logic                              eng_in_ready,
    output logic                              eng_out_valid,
    output cpu_fifo_port_pkg::byte_t          eng_out_data,
    input  wire logic                         eng_out_ready
);

    import cpu_fifo_port_pkg::*;

    // bus phase state
    logic                 addr_take;
    reg_idx_t             addr_idx;
    logic                 addr_mapped;
    logic                 wr_pend_r;
    reg_idx_t             wr_idx_r;
    word_t                hrdata_r;

    // software-visible state
    logic                 role_r;
    byte_t                readable_low_snap_r;
    byte_t                free_low_snap_r;

    // fifo attachments
    byte_t                pop_head;
    fifo_cnt_t            pop_cnt;
    logic                 pop_full;
    logic                 pop_empty;
    logic                 pop_parity;
    logic                 pop_strobe;
    byte_t                push_head;
    fifo_cnt_t            push_cnt;
    logic                 push_full;
    logic                 push_empty;
    logic                 push_parity;
    logic                 push_strobe;
    logic                 eng_pop;

    // derived counts
    count_t               readable_count;
    count_t               free_count;
    fifo_cnt_t            free_small;

    // read side of the address phase
    logic                 rd_take;
    byte_t                rd_byte;
    logic                 pop_port_hit;
    logic                 pop_side;

    // push side of the data phase
    logic                 wr_commit;
    logic                 push_port_hit;
    logic                 push_side;

    // true when a port side may move a byte: fifo attached, not in sleep,
    // a byte or free slot available, and the pointer parity matches the side, so a boundary leaves the
    // other side idle
    function automatic logic side_ok(input logic attach,
                                     input logic asleep,
                                     input logic avail,
                                     input logic parity,
                                     input logic side);
        side_ok = attach && !asleep && avail && (parity == side);
    endfunction

    // index decode shared by the read mux and the write commit
    function automatic logic idx_mapped(input reg_idx_t idx);
        idx_mapped = (idx == `IDX_ROLE_SELECT) ||
                     ((idx >= `IDX_POP_PORT_A) && (idx <= `IDX_FREE_LOW));
    endfunction

    // address phase is accepted only while the bus is ready and clocks run
    assign addr_idx    = haddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
    assign addr_mapped = (haddr[`ADDR_TOP_MSB:`ADDR_TOP_LSB] == '0) && idx_mapped(addr_idx);
    assign addr_take   = ce && hsel && hready && htrans[`HTRANS_NONSEQ_BIT];
    assign rd_take     = addr_take && !hwrite && addr_mapped;

    // zero wait states; a frozen block stalls the bus instead of losing a beat
    assign hreadyout = ce;
    assign hresp     = `HRESP_OKAY;
    assign hrdata    = hrdata_r;

    // pop port decode: side a is the even byte of a fifo word, side b the odd
    assign pop_port_hit = rd_take &&
                          ((addr_idx == `IDX_POP_PORT_A) || (addr_idx == `IDX_POP_PORT_B));
    assign pop_side     = (addr_idx == `IDX_POP_PORT_B) ? `SIDE_B : `SIDE_A;
    assign pop_strobe   = pop_port_hit &&
                          side_ok(cpu_pop_attach, sleep_mode, !pop_empty,
                                  pop_parity, pop_side);

    // count views; the readable high byte carries the valid flag from the join, the free high byte has none
    assign readable_count = {`COUNT_PAD, pop_cnt};
    assign free_small     = `FIFO_DEPTH - push_cnt;
    assign free_count     = {`COUNT_PAD, free_small};

    // read mux evaluated at the address edge; reserved bits read zero
    always_comb
    begin
        rd_byte = `BYTE_ZERO;
        unique case (addr_idx)
            `IDX_ROLE_SELECT:
            begin
                rd_byte[`ROLE_BIT] = role_r;
            end
            `IDX_POP_PORT_A,
            `IDX_POP_PORT_B:
            begin
                rd_byte = pop_strobe ? pop_head : `BYTE_ZERO;
            end
            `IDX_READABLE_HIGH:
            begin
                rd_byte[`READ_VALID_BIT] = cpu_pop_attach;
                rd_byte[`COUNT_HIGH_MSB-`COUNT_HIGH_LSB:0] =
                    readable_count[`COUNT_HIGH_MSB:`COUNT_HIGH_LSB];
            end
            `IDX_READABLE_LOW:
            begin
                rd_byte = readable_low_snap_r;
            end
            `IDX_FREE_HIGH:
            begin
                rd_byte[`COUNT_HIGH_MSB-`COUNT_HIGH_LSB:0] =
                    free_count[`COUNT_HIGH_MSB:`COUNT_HIGH_LSB];
            end
            `IDX_FREE_LOW:
            begin
                rd_byte = free_low_snap_r;
            end
            default:
            begin
                rd_byte = `BYTE_ZERO;
            end
        endcase
    end

    // read data register; unmapped and write phases return zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_r <= `WORD_ZERO;
        end
        else if (addr_take)
        begin
            hrdata_r <= rd_take ? {24'h00_0000, rd_byte} : `WORD_ZERO;
        end
    end

    // low halves are latched when the high half is read, so a pair taken high
    // first is coherent even while the engine keeps moving bytes; reading the
    // low half alone returns whatever was last latched
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            readable_low_snap_r <= `BYTE_ZERO;
            free_low_snap_r     <= `BYTE_ZERO;
        end
        else if (rd_take)
        begin
            if (addr_idx == `IDX_READABLE_HIGH)
            begin
                readable_low_snap_r <= readable_count[`COUNT_LOW_MSB:`COUNT_LOW_LSB];
            end
            if (addr_idx == `IDX_FREE_HIGH)
            begin
                free_low_snap_r <= free_count[`COUNT_LOW_MSB:`COUNT_LOW_LSB];
            end
        end
    end

    // write address captured in the address phase, committed in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= '0;
        end
        else if (ce && hready)
        begin
            wr_pend_r <= addr_take && hwrite && addr_mapped;
            wr_idx_r  <= addr_idx;
        end
    end

    assign wr_commit = ce && hready && wr_pend_r;

    // role select is deliberately not gated by sleep: software must be able
    // to pick the role before waking the engines
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            role_r <= `ROLE_RESET;
        end
        else if (wr_commit && (wr_idx_r == `IDX_ROLE_SELECT))
        begin
            role_r <= hwdata[`ROLE_BIT];
        end
    end

    // push port decode in the data phase, using the live write pointer parity
    assign push_port_hit = wr_commit &&
                           ((wr_idx_r == `IDX_PUSH_PORT_A) || (wr_idx_r == `IDX_PUSH_PORT_B));
    assign push_side     = (wr_idx_r == `IDX_PUSH_PORT_B) ? `SIDE_B : `SIDE_A;
    assign push_strobe   = push_port_hit &&
                           side_ok(cpu_push_attach, sleep_mode, !push_full,
                                   push_parity, push_side);

    // clock enables for the engines; the shared block never stops
    assign role_is_host  = role_r;
    assign shared_clk_en = 1'b1;
    assign device_clk_en = !role_r;
    assign host_clk_en   = role_r;

    // engine side handshakes; back-pressure reaches the engine through ready
    assign eng_in_ready  = !pop_full;
    assign eng_out_valid = !push_empty;
    assign eng_pop       = eng_out_ready && !push_empty;

    // engine output byte is not registered: the data port is the push area head,
    // read combinationally by pointer; the fifo memory itself is flip-flop storage
    assign eng_out_data  = push_head;

    // area filled by the engine and drained through the pop ports
    cpu_byte_fifo u_pop_area
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .push      (eng_in_valid),
        .push_data (eng_in_data),
        .pop       (pop_strobe),
        .head_data (pop_head),
        .count     (pop_cnt),
        .full      (pop_full),
        .empty     (pop_empty),
        .rd_parity (pop_parity),
        .wr_parity ()
    );

    // area filled through the push ports and drained by the engine
    cpu_byte_fifo u_push_area
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .push      (push_strobe),
        .push_data (hwdata[`COUNT_LOW_MSB:`COUNT_LOW_LSB]),
        .pop       (eng_pop),
        .head_data (push_head),
        .count     (push_cnt),
        .full      (push_full),
        .empty     (push_empty),
        .rd_parity (),
        .wr_parity (push_parity)
    );

endmodule

`default_nettype wire

// >>> rtl/cpu_fifo_port_pkg.sv
/*
 * shared types of the cpu fifo port block; assumes the map header supplies
 * all numeric constants
 */
package cpu_fifo_port_pkg;

    typedef logic [7:0]  byte_t;
    typedef logic [31:0] word_t;
    typedef logic [12:0] count_t;
    typedef logic [5:0]  reg_idx_t;
    typedef logic [6:0]  fifo_cnt_t;

endpackage
